// File: bxa_arbiter.sv
// Bus arbiter with external bus release, APB register slave
// Summary of operation
// - Release honoured only in expanded mode with release enable set.
// - Low request pin leads to acknowledge low and floated bus outputs.
// - Internal masters except external DMA keep running internally.
// - External accesses wait until the request pin is withdrawn.
// - Refresh and standby sleeps are deferred until release ends.
// - Cancel pin low when enabled and deferred work is pending.
// - Request pin high ends release and raises acknowledge.
// - Release beats simultaneous internal external access.
// - Priority: refresh, external DMA, release, other external access.
// - Bus outputs float and DMA acknowledges stay high when released.
// - Internal access may overlap release or refresh; refresh may overlap external DMA.
// - With refresh mode zero, refresh and non-DRAM access run together.
// - Highest requester gets acknowledge and owns bus until withdrawn.
// - CPU loses bus only between whole bus cycles.
// - CPU keeps bus through read-modify-write.
// - Sleeping CPU yields bus immediately.
// - Descriptor controller yields only at its defined step boundaries.
// - DMA single transfers release bus after each transfer.
// - DMA block/burst release at end; external DMA or release may preempt.
// - External DMA releases per transfer, block or burst end.
// - External DMA yields when yield bit set and internal wants outside.
// - Request with enable raises arbiter request; grant at cycle end.
// - Reset aborts any bus cycle immediately.
module bxa_arbiter
  import bxa_pkg::*;
#(
  parameter int NM = NUM_MST
)
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Master requests and status
  input  wire logic [NM-1:0] mstReq,
  input  wire logic [NM-1:0] mstYieldOk,
  input  wire logic [NM-1:0] mstExtAccess,
  input  wire logic [NM-1:0] mstNonDram,
  input  wire logic          cpuSleep,
  input  wire logic          extCycleDone,
  input  wire logic          refreshReq,
  input  wire logic          standbySleep,
  output logic [NM-1:0]      mstAck,
  output logic [NM-1:0]      extStart,
  output logic               refreshGo,
  output logic               standbyGo,
  // External pins
  input  wire logic          ext_bus_request_n,
  output logic               busAcknowledgeN,
  output logic               release_cancel_request_n,
  output logic               busOutEn,
  output logic               dmaAckForceHigh
);
  bxa_grant_if gif ();

  logic [2:0]    busCtrlQ;
  logic          refModeQ;
  logic          yieldQ;
  logic [NM-1:0] ackQ;
  logic [NM-1:0] ackD;
  logic          reqLow;
  logic          relReqLive;
  logic          released;
  logic          anyExtWant;
  logic          refreshPendQ;
  logic          standbyPendQ;
  logic          ownerFree;
  logic          refreshWins;
  logic          cancelQ;
  logic          wrEn;

  bxa_release_seq u_seq
  (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .extBusRequestN  (ext_bus_request_n),
    .busAcknowledgeN (busAcknowledgeN),
    .reqLow          (reqLow),
    .gif             (gif)
  );

  // APB slave, no wait states
  assign pready = 1'b1;
  assign wrEn   = psel && penable && pwrite;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      busCtrlQ <= BUS_CTRL_RST;
      refModeQ <= FLAG_RST;
      yieldQ   <= FLAG_RST;
    end
    else if (wrEn)
    begin
      if (paddr == BUS_CTRL_ADDR)
        busCtrlQ <= pwdata[2:0];
      else if (paddr == REFRESH_ADDR)
        refModeQ <= pwdata[REF_MODE_BIT];
      else if (paddr == EXDMA_MODE_ADDR)
        yieldQ <= pwdata[YIELD_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      if (paddr == BUS_CTRL_ADDR)
        prdata <= {29'h0, busCtrlQ};
      else if (paddr == REFRESH_ADDR)
        prdata <= {31'h0, refModeQ};
      else if (paddr == EXDMA_MODE_ADDR)
        prdata <= {31'h0, yieldQ};
      else if (paddr == STATUS_ADDR)
        prdata <= {24'h0, ackQ, standbyPendQ, refreshPendQ,
                   ~cancelQ, released};
      else
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

  assign relReqLive = reqLow && busCtrlQ[REL_EN_BIT]
                      && busCtrlQ[EXP_MODE_BIT];
  assign released   = gif.released;
  assign anyExtWant = |(mstReq & mstExtAccess);

  // refresh ahead of release; overlap with non-DRAM access
  assign refreshWins = refreshReq && !released;
  assign gif.relReq  = relReqLive && !refreshWins;
  // release beats internal external access, external DMA first
  assign gif.relGrant = !(ackQ[MST_EXDMA] && !extCycleDone)
                        && !mstReq[MST_EXDMA];
  assign gif.extCycleDone = extCycleDone;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      refreshPendQ <= FLAG_RST;
      standbyPendQ <= FLAG_RST;
    end
    else
    begin
      if (released && refreshReq)
        refreshPendQ <= 1'b1;
      else if (gif.releaseEnd)
        refreshPendQ <= 1'b0;
      if (released && standbySleep)
        standbyPendQ <= 1'b1;
      else if (gif.releaseEnd)
        standbyPendQ <= 1'b0;
    end
  end

  assign refreshGo = refreshReq && !released && !refreshPendQ
                     || refreshPendQ && gif.releaseEnd;
  assign standbyGo = standbySleep && !released && !standbyPendQ
                     || standbyPendQ && gif.releaseEnd;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cancelQ <= 1'b0;
    else
      cancelQ <= busCtrlQ[CANCEL_OE_BIT] && released
                 && (anyExtWant || refreshReq || standbySleep
                     || refreshPendQ || standbyPendQ);
  end
  assign release_cancel_request_n = ~cancelQ;

  always_comb
  begin
    ownerFree = 1'b1;
    for (int i = 0; i < NM; i++)
      if (ackQ[i] && mstReq[i] && !mstYieldOk[i]
          && !(i == MST_CPU && cpuSleep)
          && !(i == MST_DMAC && (relReqLive || mstReq[MST_EXDMA])))
        ownerFree = 1'b0;
  end

  always_comb
  begin
    ackD = ackQ & mstReq;
    if (ownerFree)
    begin
      ackD = '0;
      for (int i = 0; i < NM; i++)
        if (mstReq[i])
          ackD = '0 | (NM'(1) << i);
    end
    // external DMA yields to internal outside access
    if (ackD[MST_EXDMA] && yieldQ && mstYieldOk[MST_EXDMA]
        && |(mstReq[NM-2:0] & mstExtAccess[NM-2:0]))
      ackD[MST_EXDMA] = 1'b0;
  end

  // reset drops all grants at once
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ackQ <= '0;
    else
      ackQ <= ackD;
  end
  assign mstAck = ackQ;

  genvar g;
  generate
    for (g = 0; g < NM; g++)
    begin : g_ext
      if (g == MST_EXDMA)
        assign extStart[g] = ackQ[g] && mstExtAccess[g]
                             && !released && !gif.relReq;
      else
        assign extStart[g] = ackQ[g] && mstExtAccess[g]
                             && !released && !gif.relReq
                             && !(refreshWins && refModeQ)
                             && !(refreshWins && !mstNonDram[g]);
    end
  endgenerate

  // float bus, hold DMA acknowledges high
  assign busOutEn        = !released;
  assign dmaAckForceHigh = released;
endmodule

// File: bxa_pkg.sv
// Shared constants, register map and types of the bus arbiter
package bxa_pkg;
  // Register byte addresses
  localparam logic [11:0] BUS_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] REFRESH_ADDR    = 12'h004;
  localparam logic [11:0] EXDMA_MODE_ADDR = 12'h008;
  localparam logic [11:0] STATUS_ADDR     = 12'h00C;
  // Field positions
  localparam int REL_EN_BIT    = 0;
  localparam int CANCEL_OE_BIT = 1;
  localparam int EXP_MODE_BIT  = 2;
  localparam int REF_MODE_BIT  = 0;
  localparam int YIELD_BIT     = 0;
  // Reset values
  localparam logic [2:0] BUS_CTRL_RST = 3'h0;
  localparam logic       FLAG_RST     = 1'b0;
  // Master indices
  localparam int MST_CPU   = 0;
  localparam int MST_DTC   = 1;
  localparam int MST_DMAC  = 2;
  localparam int MST_EXDMA = 3;
  localparam int NUM_MST   = 4;
  // Release sequencer states, Gray along the usual path
  typedef enum logic [1:0]
  {
    REL_IDLE  = 2'b00,
    REL_WAIT  = 2'b01,
    REL_HELD  = 2'b11,
    REL_LEAVE = 2'b10
  } bxa_rel_t;
endpackage

// File: bxa_grant_if.sv
// Request and grant wires between arbiter core and release sequencer
interface bxa_grant_if;
  logic relReq;
  logic relGrant;
  logic released;
  logic extCycleDone;
  logic releaseEnd;
  modport core (output relReq, output extCycleDone, input relGrant,
                input released, input releaseEnd);
  modport seq (input relReq, input extCycleDone, output relGrant,
               output released, output releaseEnd);
endinterface

// File: bxa_release_seq.sv
// External bus release sequencer with pin synchroniser
module bxa_release_seq
  import bxa_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin
  input  wire logic extBusRequestN,
  output logic      busAcknowledgeN,
  output logic      reqLow,
  // To core
  bxa_grant_if.seq  gif
);
  logic     sync1Q;
  logic     sync2Q;
  bxa_rel_t stateQ;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1Q <= 1'b1;
      sync2Q <= 1'b1;
    end
    else
    begin
      sync1Q <= extBusRequestN;
      sync2Q <= sync1Q;
    end
  end

  assign reqLow = ~sync2Q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stateQ <= REL_IDLE;
    else
    begin
      case (stateQ)
        REL_IDLE:  if (gif.relReq) stateQ <= REL_WAIT;
        REL_WAIT:
          if (!gif.relReq)
            stateQ <= REL_IDLE;
          else if (gif.relGrant && gif.extCycleDone)
            stateQ <= REL_HELD;
        REL_HELD:  if (sync2Q) stateQ <= REL_LEAVE;
        REL_LEAVE: stateQ <= REL_IDLE;
        default:   stateQ <= REL_IDLE;
      endcase
    end
  end

  assign gif.released   = (stateQ == REL_HELD);
  assign gif.releaseEnd = (stateQ == REL_LEAVE);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      busAcknowledgeN <= 1'b1;
    else
      busAcknowledgeN <= ~((stateQ == REL_WAIT && gif.relReq
                            && gif.relGrant && gif.extCycleDone) ||
                           (stateQ == REL_HELD && !sync2Q));
  end
endmodule

// File: bxa_checker.sv
// Port checker for the bus arbiter with external release
module bxa_checker #(parameter int NM = 4)
(
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          rst,
  // Register bus
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pslverr,
  // Masters
  input wire logic [NM-1:0] mstReq,
  input wire logic [NM-1:0] mstYieldOk,
  input wire logic [NM-1:0] mstAck,
  input wire logic [NM-1:0] extStart,
  input wire logic          cpuSleep,
  input wire logic          refreshGo,
  input wire logic          standbyGo,
  // Pins
  input wire logic          ext_bus_request_n,
  input wire logic          busAcknowledgeN,
  input wire logic          release_cancel_request_n,
  input wire logic          busOutEn,
  input wire logic          dmaAckForceHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ctrl_q;
  // Shadow of bus control, written at access edge
  always_ff @(posedge sys_clk)
    if (rst)
      ctrl_q <= 3'h0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ctrl_q <= pwdata[2:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  float_when_rel_a: assert property
    (!busAcknowledgeN |-> !busOutEn && dmaAckForceHigh)
    else $error("outputs driven while released");
  rel_needs_en_a: assert property
    ($fell(busAcknowledgeN) |-> ctrl_q[0] && ctrl_q[2])
    else $error("release without enable");
  sync_delay_a: assert property
    ($fell(ext_bus_request_n) && busAcknowledgeN |=> busAcknowledgeN [*2])
    else $error("acknowledge too early");
  defer_work_a: assert property
    (!busAcknowledgeN && !ext_bus_request_n
      |-> !refreshGo && !standbyGo && extStart == '0)
    else $error("work started during release");
  cancel_oe_a: assert property
    (!release_cancel_request_n |-> ctrl_q[1])
    else $error("cancel driven while disabled");
  unmapped_err_a: assert property
    (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("no error on unmapped access");
  cpu_keeps_a: assert property
    (mstAck[0] && mstReq[0] && !mstYieldOk[0] && !cpuSleep |=> mstAck[0])
    else $error("cpu lost bus mid cycle");
  one_owner_a: assert property ($onehot0(mstAck))
    else $error("two owners");
  reset_abort_a: assert property
    (disable iff (1'b0) rst |=> mstAck == '0 && busAcknowledgeN)
    else $error("reset did not abort");
endmodule

// File: bxa_ext_master.sv
// Model of the outside master that borrows the external bus
module bxa_ext_master
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic want,
  // Pins
  input wire logic busAcknowledgeN,
  input wire logic release_cancel_request_n,
  output logic     ext_bus_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic yielded_q = 1'b0;
  initial ext_bus_request_n = 1'b1;
  // gives back once cancel seen, sticky
  always @(posedge sys_clk)
    if (!want)
      yielded_q <= 1'b0;
    else if (!release_cancel_request_n && !busAcknowledgeN)
      yielded_q <= 1'b1;
  always @(posedge sys_clk)
    ext_bus_request_n <= !want || yielded_q
      || (!release_cancel_request_n && !busAcknowledgeN);
endmodule

// File: bxa_arbiter_tb.sv
// Testbench for the bus arbiter with external release
module bxa_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bxa_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, cpuSleep = 0, extCycleDone = 1;
  logic refreshReq = 0, standbySleep = 0, refreshGo, standbyGo, want = 0;
  logic [3:0] mstReq = '0, mstYieldOk = '0, mstExtAccess = '0;
  logic [3:0] mstNonDram = '0, mstAck, extStart;
  logic ext_bus_request_n, busAcknowledgeN, release_cancel_request_n;
  logic busOutEn, dmaAckForceHigh;
  int mismatches = 0, checks = 0, n;
  bxa_arbiter dut_u (.*);
  bxa_ext_master ext_u (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Setup cycle, then hold until pready at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      tally_and_finish();
    end
    // Idle edge so a following setup never reassigns psel now
    @(posedge sys_clk);
  endtask
  task automatic wait_ack(input logic lvl);
    for (n = 0; n < 30 && busAcknowledgeN !== lvl; n++)
      @(posedge sys_clk);
    if (n == 30)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, STATUS_ADDR, 32'h0);
    // Cancel bit mirrors the inactive-high pin level
    chk(rd, 32'h0000_0002);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask
  // Expanded mode clear: request ignored
  task automatic t_refused();
    apb(1'b1, BUS_CTRL_ADDR, 32'h3);
    want <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk(busAcknowledgeN, 1'b1);
    want <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_release();
    apb(1'b1, BUS_CTRL_ADDR, 32'h7);
    want <= 1'b1;
    wait_ack(1'b0);
    chk({busOutEn, dmaAckForceHigh}, 2'b01);
    refreshReq <= 1'b1;
    standbySleep <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk({refreshGo, standbyGo}, 2'b00);
    chk(release_cancel_request_n, 1'b0);
    wait_ack(1'b1);
    repeat (2) @(posedge sys_clk);
    chk({refreshGo, standbyGo}, 2'b11);
    refreshReq <= 1'b0;
    standbySleep <= 1'b0;
    want <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_grant();
    mstYieldOk <= 4'hF;
    mstReq <= 4'hF;
    repeat (3) @(posedge sys_clk);
    chk(mstAck, 4'h8);
    mstReq <= 4'h0;
    mstYieldOk <= 4'h0;
    repeat (2) @(posedge sys_clk);
    mstReq <= 4'h1;
    mstExtAccess <= 4'h1;
    repeat (3) @(posedge sys_clk);
    chk(mstAck, 4'h1);
    chk(extStart, 4'h1);
    mstReq <= 4'h9;
    repeat (3) @(posedge sys_clk);
    chk(mstAck, 4'h1);
    cpuSleep <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(mstAck, 4'h8);
    cpuSleep <= 1'b0;
    mstReq <= 4'h1;
  endtask
  // Reset while released and owned
  task automatic t_reset();
    apb(1'b1, BUS_CTRL_ADDR, 32'h7);
    want <= 1'b1;
    wait_ack(1'b0);
    chk(extStart, 4'h0);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({busAcknowledgeN, mstAck}, 5'h10);
    want <= 1'b0;
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_refused();
    t_release();
    t_grant();
    t_reset();
    tally_and_finish();
  end
endmodule
bind bxa_arbiter bxa_checker #(.NM(NM)) chk_u (.*);
